// ---- design/dafr_regs.v ----
// address select and output features registers with their output control
`timescale 1ns/1ps
`default_nettype none
`include "dafr_consts.vh"
module dafr_regs (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port behind the serial control bus
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // configuration from the first configuration register
    input wire register_control,
    input wire legacy_mode,
    // straps and pins
    input wire [6:0] bus_address_strap,
    input wire force_low_strap,
    input wire sleep_state_pin,
    // link state and recovered video
    input wire link_locked,
    input wire [23:0] color_data_in,
    input wire hsync_in,
    input wire vsync_in,
    input wire video_data_valid_in,
    input wire pclk_in,
    // device address
    output reg [6:0] bus_address,
    output reg bus_address_valid,
    // oscillator control
    output reg [2:0] oscillator_frequency_select,
    output reg oscillator_enable,
    // parallel outputs
    output reg [23:0] color_data_out,
    output reg hsync_out,
    output reg vsync_out,
    output reg video_data_valid_out,
    output reg pclk_out,
    output reg parallel_oe,
    output reg lock_out,
    output reg pass_out
);
    // register contents; reserved address values are kept, only flagged invalid
    reg [7:0] bus_address_select;
    reg [7:0] output_features_one;

    // three stage pin synchronisers, stage 1 feeds only stage 2
    // straps move slowly; waiting for stages 2 and 3 to agree costs a
    // cycle but keeps a single glitch from reaching the address
    reg [8:0] pin_s1;
    reg [8:0] pin_s2;
    reg [8:0] pin_s3;
    reg [8:0] pin_stable;
    wire [8:0] pin_raw = {sleep_state_pin, force_low_strap, bus_address_strap};
    wire [6:0] strap_addr = pin_stable[6:0];
    wire strap_force_low = pin_stable[7];
    wire sleep_pin = pin_stable[8];

    always @(posedge clk) begin
        if (rst) begin
            pin_s1 <= 9'h000;
            pin_s2 <= 9'h000;
            pin_s3 <= 9'h000;
            pin_stable <= 9'h000;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_stable <= pin_s3;
            end
        end
    end

    // register writes and reads
    // other indices are ignored on write and read back as zero
    always @(posedge clk) begin
        if (rst) begin
            bus_address_select <= `DAFR_ADDR_SEL_RESET;
            output_features_one <= `DAFR_FEAT1_RESET;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `DAFR_ADDR_SEL_OFFSET) begin
                bus_address_select <= reg_wdata;
            end
            if (reg_wr && reg_addr == `DAFR_FEAT1_OFFSET) begin
                output_features_one <= reg_wdata;
            end
            // read data is registered, so it trails reg_addr by one cycle
            case (reg_addr)
                `DAFR_ADDR_SEL_OFFSET: reg_rdata <= bus_address_select;
                `DAFR_FEAT1_OFFSET: reg_rdata <= output_features_one;
                default: reg_rdata <= `DAFR_UNMAPPED_READ;
            endcase
        end
    end

    // effective features: pin defaults unless register control is set
    reg eff_release;
    reg eff_sleep_sel;
    reg [1:0] eff_map;
    reg eff_bypass;
    reg [2:0] eff_osc;

    always @* begin
        if (register_control) begin
            eff_release = output_features_one[`DAFR_RELEASE_BIT];
            eff_sleep_sel = output_features_one[`DAFR_SLEEP_SEL_BIT];
            eff_map = output_features_one[`DAFR_MAP_MSB:`DAFR_MAP_LSB];
            eff_bypass = output_features_one[`DAFR_BYPASS_BIT];
            eff_osc = output_features_one[`DAFR_OSC_MSB:0];
        end else begin
            // pin defaults: force low stays armed unless the strap is off
            eff_release = 1'b0;
            eff_sleep_sel = sleep_pin;
            eff_map = `DAFR_MAP_BITS_ON_LSB;
            eff_bypass = 1'b0;
            eff_osc = `DAFR_OSC_OFF;
        end
    end

    // address source ignores register control on purpose
    wire [6:0] next_bus_address = bus_address_select[`DAFR_ADDR_SRC_BIT] ?
        bus_address_select[`DAFR_ADDR_MSB:0] : strap_addr;
    wire next_addr_valid = (next_bus_address == `DAFR_ADDR_VALID_A) ||
        (next_bus_address == `DAFR_ADDR_VALID_B) ||
        (next_bus_address == `DAFR_ADDR_VALID_C) ||
        (next_bus_address == `DAFR_ADDR_VALID_D);

    // bypass wins over the strap; feature active means held low until released
    wire force_low_feature = strap_force_low && !eff_bypass;
    wire hold_low = force_low_feature && link_locked && !eff_release;
    // lock never joins the hold itself, it only gates it

    // legacy LSB fill, one slice per color channel
    // only the two lowest bits of each channel are touched
    wire [23:0] mapped_color;
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
            wire [7:0] c = color_data_in[ch*8 +: 8];
            reg [1:0] lsb;
            always @* begin
                lsb = c[1:0];
                if (legacy_mode) begin
                    case (eff_map)
                        `DAFR_MAP_BITS_ON_LSB: lsb = c[`DAFR_LEGACY_SRC_LSB +: 2];
                        `DAFR_MAP_PASS: lsb = c[1:0];
                        default: lsb = 2'h0;
                    endcase
                end
            end
            assign mapped_color[ch*8 +: 8] = {c[7:2], lsb};
        end
    endgenerate

    // registered outputs; lock and pass are never forced low
    // an unlocked link is treated as the sleep state

    always @(posedge clk) begin
        if (rst) begin
            bus_address <= 7'h00;
            bus_address_valid <= 1'b0;
            oscillator_frequency_select <= `DAFR_OSC_OFF;
            oscillator_enable <= 1'b0;
            color_data_out <= 24'h000000;
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
            video_data_valid_out <= 1'b0;
            pclk_out <= 1'b0;
            parallel_oe <= 1'b0;
            lock_out <= 1'b0;
            pass_out <= 1'b1;
        end else begin
            bus_address <= next_bus_address;
            bus_address_valid <= next_addr_valid;
            // the oscillator itself is outside; only its select and enable leave here
            oscillator_frequency_select <= eff_osc;
            oscillator_enable <= (eff_osc != `DAFR_OSC_OFF);
            lock_out <= link_locked;
            pass_out <= 1'b1;
            if (!link_locked) begin
                // sleep state: low when selected, otherwise released
                color_data_out <= 24'h000000;
                hsync_out <= 1'b0;
                vsync_out <= 1'b0;
                video_data_valid_out <= 1'b0;
                pclk_out <= 1'b0;
                parallel_oe <= eff_sleep_sel;
            end else if (hold_low) begin
                // locked but not released: driven low, pins stay enabled
                color_data_out <= 24'h000000;
                hsync_out <= 1'b0;
                vsync_out <= 1'b0;
                video_data_valid_out <= 1'b0;
                pclk_out <= 1'b0;
                parallel_oe <= 1'b1;
            end else begin
                // released: video passes with one cycle of latency
                color_data_out <= mapped_color;
                hsync_out <= hsync_in;
                vsync_out <= vsync_in;
                video_data_valid_out <= video_data_valid_in;
                pclk_out <= pclk_in;
                parallel_oe <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- design/dafr_consts.vh ----
// register offsets, field positions and reset values for the address and features bank
`ifndef DAFR_CONSTS_VH
`define DAFR_CONSTS_VH
`define DAFR_ADDR_SEL_OFFSET 8'h01
`define DAFR_FEAT1_OFFSET 8'h02
`define DAFR_ADDR_SEL_RESET 8'h70
`define DAFR_FEAT1_RESET 8'h00
`define DAFR_ADDR_SRC_BIT 7
`define DAFR_ADDR_MSB 6
`define DAFR_RELEASE_BIT 7
`define DAFR_SLEEP_SEL_BIT 6
`define DAFR_MAP_MSB 5
`define DAFR_MAP_LSB 4
`define DAFR_LEGACY_SRC_LSB 4
`define DAFR_BYPASS_BIT 3
`define DAFR_OSC_MSB 2
`define DAFR_MAP_BITS_ON_LSB 2'h0
`define DAFR_MAP_PASS 2'h1
`define DAFR_OSC_OFF 3'h0
`define DAFR_ADDR_VALID_A 7'h71
`define DAFR_ADDR_VALID_B 7'h72
`define DAFR_ADDR_VALID_C 7'h73
`define DAFR_ADDR_VALID_D 7'h76
`define DAFR_UNMAPPED_READ 8'h00
`endif

// ---- tb/dafr_host.sv ----
// control bus host model
`timescale 1ns/1ps
`default_nettype none
module dafr_host (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr = 8'h00,
    output logic reg_wr = 1'b0,
    output logic [7:0] reg_wdata = 8'h00
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ---- tb/dafr_regs_asserts.sv ----
// checker for the address and features bank
`timescale 1ns/1ps
`default_nettype none
module dafr_regs_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // configuration and link
    input wire logic register_control,
    input wire logic legacy_mode,
    input wire logic link_locked,
    input wire logic hsync_in,
    // address and oscillator
    input wire logic [6:0] bus_address,
    input wire logic bus_address_valid,
    input wire logic [2:0] oscillator_frequency_select,
    input wire logic oscillator_enable,
    // parallel outputs
    input wire logic [23:0] color_data_out,
    input wire logic hsync_out,
    input wire logic pclk_out,
    input wire logic parallel_oe,
    input wire logic lock_out
);
    logic [7:0] feat;
    always @(posedge clk)
        if (rst) feat <= 8'h00;
        else if (reg_wr && reg_addr == 8'h02) feat <= reg_wdata;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_lk; link_locked |=> lock_out; endproperty
    a_lk: assert property (p_lk) else $error("lock lag");
    property p_ul; !link_locked |=> !lock_out && color_data_out == 24'h0 && !pclk_out; endproperty
    a_ul: assert property (p_ul) else $error("unlocked out");
    property p_sl; !link_locked && register_control |=> parallel_oe == $past(feat[6]); endproperty
    a_sl: assert property (p_sl) else $error("sleep oe");
    property p_va; bus_address_valid == (bus_address inside {7'h71, 7'h72, 7'h73, 7'h76}); endproperty
    a_va: assert property (p_va) else $error("valid");
    property p_os; oscillator_enable == (oscillator_frequency_select != 3'h0); endproperty
    a_os: assert property (p_os) else $error("osc en");
    property p_nr; !register_control [*2] |=> oscillator_frequency_select == 3'h0; endproperty
    a_nr: assert property (p_nr) else $error("osc ctl");
    property p_ad; reg_wr && reg_addr == 8'h01 && reg_wdata[7] ##1 !reg_wr
        |=> bus_address == $past(reg_wdata[6:0], 2); endproperty
    a_ad: assert property (p_ad) else $error("addr");
    property p_vd; link_locked && register_control && feat[7] && !legacy_mode
        |=> hsync_out == $past(hsync_in) && parallel_oe; endproperty
    a_vd: assert property (p_vd) else $error("video");
endmodule
`default_nettype wire

// ---- tb/test_dafr_regs.sv ----
// testbench for the address and features bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t %h %h", $time, a, e); end end
module test_dafr_regs;
    logic clk = 0, rst = 1, lk = 0, rc = 0, leg = 0, fls = 0, slp = 0;
    logic [27:0] vid = 0;
    logic [7:0] d;
    wire [27:0] vo;
    wire [7:0] ra, rw, rdat;
    wire [6:0] ba;
    wire [2:0] osc;
    wire wr, bav, osce, oe, lko, pso;
    integer bad_count = 0, checks_done = 0, seed = 32'hce11, feat = 0, i;
    logic [6:0] strap = 7'h72;
    logic [34:0] ids = {7'h70, 7'h76, 7'h73, 7'h72, 7'h71};
    dafr_regs uut (.clk(clk), .rst(rst), .reg_addr(ra), .reg_wr(wr), .reg_wdata(rw),
        .reg_rdata(rdat), .register_control(rc), .legacy_mode(leg),
        .bus_address_strap(strap), .force_low_strap(fls), .sleep_state_pin(slp),
        .link_locked(lk), .color_data_in(vid[27:4]), .hsync_in(vid[3]), .vsync_in(vid[2]),
        .video_data_valid_in(vid[1]), .pclk_in(vid[0]), .bus_address(ba),
        .bus_address_valid(bav), .oscillator_frequency_select(osc), .oscillator_enable(osce),
        .color_data_out(vo[27:4]), .hsync_out(vo[3]), .vsync_out(vo[2]),
        .video_data_valid_out(vo[1]), .pclk_out(vo[0]), .parallel_oe(oe), .lock_out(lko),
        .pass_out(pso));
    dafr_host host (.clk(clk), .reg_rdata(rdat), .reg_addr(ra), .reg_wr(wr), .reg_wdata(rw));
    function automatic logic [27:0] ev;
        logic [23:0] c;
        logic [1:0] m;
        c = vid[27:4];
        m = rc ? feat[5:4] : 2'h0;
        for (int k = 0; k < 24; k += 8)
            if (leg && m != 2'h1) c[k+:2] = (m == 2'h0) ? c[k+4+:2] : 2'h0;
        if (!lk || (fls && !(rc && (feat[7] || feat[3])))) return 28'h0;
        return {c, vid[3:0]};
    endfunction
    task automatic settle;
        @(posedge clk);
        vid <= $random(seed);
        repeat (4) @(posedge clk);
        #1;
        `CHK(vo, ev())
        `CHK(oe, lk ? 1'b1 : rc ? feat[6] : slp)
        `CHK(({lko, pso}), ({lk, 1'b1}))
        `CHK(osc, rc ? feat[2:0] : 3'h0)
        `CHK(osce, rc && feat[2:0] != 0)
    endtask
    task report_and_stop;
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial forever #25 clk = ~clk;
    initial begin
        #300000;
        bad_count++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        host.rd(8'h01, d);
        `CHK(d, 8'h70)
        host.wr(8'h05, 8'hff);
        host.rd(8'h05, d);
        `CHK(d, 8'h00)
        for (i = 0; i < 7; i++) begin
            @(posedge clk);
            strap <= (i == 6) ? 7'h70 : 7'h72;
            host.wr(8'h01, i < 5 ? {1'b1, ids[i*7 +: 7]} : 8'h05);
            settle;
            `CHK(ba, i < 5 ? ids[i*7 +: 7] : strap)
            `CHK(bav, i < 4 || i == 5)
        end
        for (i = 0; i < 64; i++) begin
            d = $random(seed);
            d[2:0] = i[2:0];
            d[5:4] = i[4:3];
            @(posedge clk);
            {lk, rc, leg, fls, slp} <= $random(seed);
            host.wr(8'h02, d);
            feat = d;
            settle;
            host.rd(8'h02, d);
            `CHK(d, feat[7:0])
        end
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        feat = 0;
        host.rd(8'h01, d);
        `CHK(d, 8'h70)
        host.rd(8'h02, d);
        `CHK(d, 8'h00)
        settle;
        `CHK(ba, strap)
        `CHK(bav, 1'b0)
        report_and_stop;
    end
endmodule
bind dafr_regs dafr_regs_asserts chk (
    .clk(clk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .register_control(register_control),
    .legacy_mode(legacy_mode),
    .link_locked(link_locked),
    .hsync_in(hsync_in),
    .bus_address(bus_address),
    .bus_address_valid(bus_address_valid),
    .oscillator_frequency_select(oscillator_frequency_select),
    .oscillator_enable(oscillator_enable),
    .color_data_out(color_data_out),
    .hsync_out(hsync_out),
    .pclk_out(pclk_out),
    .parallel_oe(parallel_oe),
    .lock_out(lock_out)
);
`default_nettype wire
